// *** hdl/sdram_mode_map.vh ***
// Constants for the SDRAM mode and timing control block.
// Assumes a 10 MHz aclk; included by bare name from the design files.
`ifndef SDRAM_MODE_MAP_VH
`define SDRAM_MODE_MAP_VH
`define MT_OFFSET      8'h53
`define MT_ADDR        12'h14C
`define MT_RESET       8'h00
`define MT_MODE_HI     7
`define MT_MODE_LO     5
`define MT_CYC_BIT     4
`define MT_CAS_BIT     2
`define MT_RCD_BIT     1
`define MT_RP_BIT      0
`define MT_WMASK       8'hF7
`define MODE_SELF      3'h0
`define MODE_REF156    3'h1
`define MODE_REF78     3'h2
`define MODE_NOP       3'h4
`define MODE_PREALL    3'h5
`define MODE_MRS       3'h6
`define MODE_CBR       3'h7
`define CMD_NOP        3'h7
`define CMD_ACT        3'h3
`define CMD_READ       3'h5
`define CMD_WRITE      3'h4
`define CMD_PRE        3'h2
`define CMD_REF        3'h1
`define CMD_MRS        3'h0
`define CLK_MHZ        10
`define REF156_NS      15600
`define REF78_NS       7800
`define REF156_CYC     ((`REF156_NS * `CLK_MHZ) / 1000)
`define REF78_CYC      ((`REF78_NS * `CLK_MHZ) / 1000)
`endif

// *** hdl/sdram_cmd_seq.v ***
// Command sequencer: turns one request into an SDRAM command train.
// Assumes timing selects stay stable while busy.
`timescale 1ns/10ps
`include "sdram_mode_map.vh"
module sdram_cmd_seq
(
  input  wire        aclk,      // Clock
  input  wire        aresetn,   // Sync reset, active low
  input  wire        start,     // Begin a sequence
  input  wire [2:0]  kind,      // Mode code to execute
  input  wire        wr,        // Write access
  input  wire [11:0] addr,      // Row/col/command address
  input  wire        bank,      // Bank select
  input  wire        cyc_sel,   // Cycle time select
  input  wire        cas_sel,   // CAS latency select
  input  wire        rcd_sel,   // Activate delay select
  input  wire        rp_sel,    // Precharge time select
  output reg         busy,      // Sequence running
  output reg         done,      // Last cycle pulse
  output reg  [2:0]  cmd,       // Command to memory
  output reg  [11:0] mem_addr,  // Address lines
  output reg         mem_bank   // Bank select line
);
  localparam S_IDLE = 2'h0;
  localparam S_ACT  = 2'h1;
  localparam S_WAIT = 2'h2;
  reg [1:0] st_r;
  reg [3:0] cnt_r;
  reg       rw_phase_r;

  // Wait after a command, in clocks minus one
  function [3:0] gap;
    input [2:0] k;
    input       rp, rcd, cyc;
    begin
      case (k)
        `MODE_PREALL: gap = rp ? 4'h1 : 4'h2;
        `MODE_CBR:    gap = cyc ? 4'h7 : 4'h6;
        `MODE_MRS:    gap = 4'h1;
        default:      gap = 4'h0;
      endcase
    end
  endfunction

  always @(posedge aclk)
  begin
    done <= 1'b0;
    cmd  <= `CMD_NOP;
    if (!aresetn)
    begin
      st_r       <= S_IDLE;
      cnt_r      <= 4'h0;
      rw_phase_r <= 1'b0;
      busy       <= 1'b0;
      mem_addr   <= 12'h000;
      mem_bank   <= 1'b0;
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          if (start)
          begin
            busy     <= 1'b1;
            mem_addr <= addr;
            mem_bank <= bank;
            case (kind)
              `MODE_NOP:    cmd <= `CMD_NOP;
              `MODE_PREALL: cmd <= `CMD_PRE;
              `MODE_MRS:    cmd <= `CMD_MRS;
              `MODE_CBR:    cmd <= `CMD_REF;
              default:      cmd <= `CMD_ACT;
            endcase
            if (kind == `MODE_PREALL)
              mem_addr <= 12'h400;
            if (kind == `MODE_REF156 || kind == `MODE_REF78)
            begin
              st_r  <= S_ACT;
              // Access goes out when the count reaches one: 3 or 2 clocks after activate
              cnt_r <= rcd_sel ? 4'h2 : 4'h3;
            end
            else
            begin
              st_r  <= S_WAIT;
              cnt_r <= gap(kind, rp_sel, rcd_sel, cyc_sel);
            end
          end
        end
        S_ACT:
        begin
          if (cnt_r == 4'h1)
          begin
            cmd   <= wr ? `CMD_WRITE : `CMD_READ;
            st_r  <= S_WAIT;
            // Read waits CAS latency, then precharge after tRAS
            cnt_r <= (wr ? 4'h1 : (cas_sel ? 4'h2 : 4'h3))
                     + (cyc_sel ? 4'h2 : 4'h1);
            rw_phase_r <= 1'b1;
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        S_WAIT:
        begin
          if (cnt_r == 4'h0)
          begin
            if (rw_phase_r)
            begin
              cmd        <= `CMD_PRE;
              rw_phase_r <= 1'b0;
              cnt_r      <= rp_sel ? 4'h1 : 4'h2;
            end
            else
            begin
              st_r <= S_IDLE;
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule // sdram_cmd_seq

// *** hdl/sdram_mode_timing_control.v ***
// Top: AXI4-Lite holder of the mode/timing register and the mode engine.
// Assumes one outstanding host access; memory is modelled only by commands.
`timescale 1ns/10ps
`include "sdram_mode_map.vh"
module sdram_mode_timing_control
(
  input  wire        aclk,          // Clock, 10 MHz
  input  wire        aresetn,       // Sync reset, active low
  input  wire [11:0] s_axi_awaddr,  // Write address
  input  wire        s_axi_awvalid, // Write address valid
  output wire        s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write strobes
  input  wire        s_axi_wvalid,  // Write data valid
  output wire        s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [11:0] s_axi_araddr,  // Read address
  input  wire        s_axi_arvalid, // Read address valid
  output wire        s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read valid
  input  wire        s_axi_rready,  // Read ready
  input  wire        host_req,      // Host cycle to memory
  input  wire        host_wr,       // Host cycle is a write
  input  wire [11:0] host_addr,     // Mapped memory address
  input  wire        host_bank,     // Mapped bank select
  output wire        host_ack,      // Host cycle finished, pulse
  output wire [2:0]  mem_cmd,       // Command {ras_n,cas_n,we_n}
  output wire [11:0] mem_addr_lines,// Memory address lines
  output wire        mem_bank_sel,  // Bank select line 0
  output reg         mem_cke,       // Clock enable, low in self-refresh
  output wire        refresh_busy   // Own refresh running
);
  ////////////////////////////////////////////////////////////////////
  reg  [7:0]  dram_mode_timing_r;
  reg  [2:0]  active_mode_r;
  reg         aw_got_r, w_got_r;
  reg  [11:0] aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg  [10:0] ref_cnt_r;
  reg         ref_due_r;
  reg         own_ref_r;
  reg         seq_start;
  reg  [2:0]  seq_kind;
  wire        seq_busy, seq_done;
  wire [2:0]  sdram_op_mode_sel;

  assign sdram_op_mode_sel = dram_mode_timing_r[`MT_MODE_HI:`MT_MODE_LO];

  function normal_mode;
    input [2:0] m;
    begin
      normal_mode = (m == `MODE_REF156) || (m == `MODE_REF78);
    end
  endfunction

  // The register index 53h counts 32-bit words, so it sits alone in the word at 14Ch
  function mt_hit;
    input [11:0] a;
    begin
      mt_hit = (a[11:2] == {2'h0, `MT_OFFSET});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r           <= 1'b0;
      w_got_r            <= 1'b0;
      aw_addr_r          <= 12'h000;
      w_data_r           <= 32'h00000000;
      w_strb_r           <= 4'h0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= 2'h0;
      dram_mode_timing_r <= `MT_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r)
      begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (mt_hit(aw_addr_r))
        begin
          s_axi_bresp <= 2'h0;
          // Reserved bit 3 stays zero; same byte lane as the read path
          if (w_strb_r[0])
            dram_mode_timing_r <= w_data_r[7:0] & `MT_WMASK;
        end
        else
          s_axi_bresp <= 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      if (mt_hit(s_axi_araddr))
      begin
        s_axi_rdata <= {24'h000000, dram_mode_timing_r};
        s_axi_rresp <= 2'h0;
      end
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Mode adopted only while the sequencer is idle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      active_mode_r <= `MODE_SELF;
      mem_cke       <= 1'b0;
    end
    else if (!seq_busy && !seq_start)
    begin
      active_mode_r <= sdram_op_mode_sel;
      mem_cke       <= (sdram_op_mode_sel != `MODE_SELF);
    end
  end

  // Refresh interval timer, runs only in the normal modes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_cnt_r <= 11'h000;
      ref_due_r <= 1'b0;
    end
    else if (!normal_mode(active_mode_r))
    begin
      ref_cnt_r <= 11'h000;
      ref_due_r <= 1'b0;
    end
    else
    begin
      // Clear first so that a new interval ending in the same cycle wins
      if (seq_start && seq_kind == `MODE_CBR)
        ref_due_r <= 1'b0;
      // Restart on a pending mode change: a count left from the long interval
      // would otherwise run past the short limit and wrap
      if (active_mode_r != sdram_op_mode_sel)
        ref_cnt_r <= 11'h000;
      else if ((active_mode_r == `MODE_REF156 && ref_cnt_r == `REF156_CYC - 1) ||
               (active_mode_r == `MODE_REF78 && ref_cnt_r == `REF78_CYC - 1))
      begin
        ref_cnt_r <= 11'h000;
        ref_due_r <= 1'b1;
      end
      else
        ref_cnt_r <= ref_cnt_r + 11'h001;
    end
  end

  // Dispatch: refresh wins over a host cycle; 011 and 000 ignore hosts
  always @*
  begin
    seq_start = 1'b0;
    seq_kind  = active_mode_r;
    // Skip the acknowledge cycle: the host still holds its finished request there
    if (!seq_busy && !seq_done && active_mode_r == sdram_op_mode_sel)
    begin
      if (normal_mode(active_mode_r) && ref_due_r)
      begin
        seq_start = 1'b1;
        seq_kind  = `MODE_CBR;
      end
      else if (host_req && (normal_mode(active_mode_r) || active_mode_r[2]))
        seq_start = 1'b1;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      own_ref_r <= 1'b0;
    else if (seq_start)
      own_ref_r <= normal_mode(active_mode_r) && ref_due_r;
  end

  assign host_ack     = seq_done && !own_ref_r;
  assign refresh_busy = seq_busy && own_ref_r;

  sdram_cmd_seq u_seq
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (seq_start),
    .kind     (seq_kind),
    .wr       (host_wr),
    .addr     (host_addr),
    .bank     (host_bank),
    .cyc_sel  (dram_mode_timing_r[`MT_CYC_BIT]),
    .cas_sel  (dram_mode_timing_r[`MT_CAS_BIT]),
    .rcd_sel  (dram_mode_timing_r[`MT_RCD_BIT]),
    .rp_sel   (dram_mode_timing_r[`MT_RP_BIT]),
    .busy     (seq_busy),
    .done     (seq_done),
    .cmd      (mem_cmd),
    .mem_addr (mem_addr_lines),
    .mem_bank (mem_bank_sel)
  );
endmodule // sdram_mode_timing_control

// *** bench/sdram_mtc_assertions.sv ***
// Concurrent checks on the top-level ports of the mode/timing block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module sdram_mtc_assertions
(
  input wire        aclk,           // Clock
  input wire        aresetn,        // Sync reset, active low
  input wire        s_axi_awready,  // Write address ready
  input wire [1:0]  s_axi_bresp,    // Write response
  input wire        s_axi_bvalid,   // Write response valid
  input wire        s_axi_bready,   // Write response ready
  input wire        s_axi_arvalid,  // Read address valid
  input wire        s_axi_arready,  // Read address ready
  input wire        s_axi_rvalid,   // Read valid
  input wire [11:0] host_addr,      // Mapped memory address
  input wire        host_bank,      // Mapped bank select
  input wire        host_ack,       // Host cycle finished
  input wire [2:0]  mem_cmd,        // Memory command
  input wire [11:0] mem_addr_lines, // Memory address lines
  input wire        mem_bank_sel,   // Bank select line 0
  input wire        mem_cke,        // Clock enable
  input wire        refresh_busy    // Own refresh running
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  property p_cmd_gap; mem_cmd != 3'h7 |=> mem_cmd == 3'h7; endproperty
  a_cmd_gap: assert property (p_cmd_gap) else $error("command not single");
  property p_act_rcd;
    mem_cmd == 3'h3 |=> mem_cmd == 3'h7 ##[1:2] (mem_cmd == 3'h5 || mem_cmd == 3'h4);
  endproperty
  a_act_rcd: assert property (p_act_rcd) else $error("activate spacing");
  property p_pre_ack; mem_cmd == 3'h2 && !refresh_busy |-> ##[2:4] host_ack; endproperty
  a_pre_ack: assert property (p_pre_ack) else $error("precharge end");
  property p_mrs_addr;
    mem_cmd == 3'h0 |-> mem_addr_lines == host_addr && mem_bank_sel == host_bank;
  endproperty
  a_mrs_addr: assert property (p_mrs_addr) else $error("mode set address");
  property p_self; !mem_cke |-> mem_cmd != 3'h1 && !host_ack; endproperty
  a_self: assert property (p_self) else $error("activity in self refresh");
  property p_ack; host_ack |=> !host_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack not a pulse");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_b_hold; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write taken early");
endmodule // sdram_mtc_assertions
bind sdram_mode_timing_control sdram_mtc_assertions sdram_mtc_assertions_i
  (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .host_addr, .host_bank, .host_ack,
   .mem_cmd, .mem_addr_lines, .mem_bank_sel, .mem_cke, .refresh_busy);

// *** bench/sdram_rows_model.sv ***
// Behavioural memory rows: tallies the commands they receive.
// Assumes one-cycle commands on aclk; the tallies and last command ignore the bus while cke is low.
`timescale 1ns/10ps
module sdram_rows_model
(
  input  wire        aclk,                    // Clock
  input  wire        mem_cke,                 // Clock enable
  input  wire [2:0]  mem_cmd,                 // {ras_n,cas_n,we_n}
  input  wire [11:0] mem_addr_lines,          // Address lines
  input  wire        mem_bank_sel,            // Bank select
  output reg  [15:0] n_cmd     = 16'h0000,    // Non-idle commands
  output reg  [15:0] n_ref     = 16'h0000,    // Refresh commands
  output reg  [2:0]  last_cmd  = 3'h7,        // Last non-idle command
  output reg  [12:0] last_addr = 13'h0000,    // Its {bank, address}
  output reg  [3:0]  act_gap   = 4'h0         // Clocks activate to access
);
  reg [3:0] since_act = 4'h0;
  always @(posedge aclk)
  begin
    since_act <= (mem_cmd == 3'h3) ? 4'h1 : since_act + 4'h1;
    if (mem_cke && mem_cmd != 3'h7)
    begin
      n_cmd     <= n_cmd + 16'h0001;
      last_cmd  <= mem_cmd;
      last_addr <= {mem_bank_sel, mem_addr_lines};
    end
    if (mem_cke && mem_cmd == 3'h1) n_ref <= n_ref + 16'h0001;
    if (mem_cmd == 3'h5 || mem_cmd == 3'h4) act_gap <= since_act;
  end
endmodule // sdram_rows_model

// *** bench/test_sdram_mode_timing_control.sv ***
// Self-checking bench: AXI4-Lite register tasks plus host memory cycles.
// Assumes the memory rows model only observes; no memory data is returned.
`timescale 1ns/10ps
`include "sdram_mode_map.vh"
module test_sdram_mode_timing_control;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, host_addr = 12'h000;
  reg  [31:0] s_axi_wdata = 32'h00000000;
  reg  [3:0]  s_axi_wstrb = 4'h1;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg         host_req = 1'b0, host_wr = 1'b0, host_bank = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        host_ack, mem_bank_sel, mem_cke, refresh_busy;
  wire [2:0]  mem_cmd, last_cmd;
  wire [11:0] mem_addr_lines;
  wire [15:0] n_cmd, n_ref;
  wire [12:0] last_addr;
  wire [3:0]  act_gap;
  integer     n_mismatch = 0, n_tests = 0, i, t0;
  reg  [31:0] rd;
  reg  [1:0]  rs, bs;
  reg         ok;
  always #50 aclk = ~aclk;
  sdram_mode_timing_control sdram_mode_timing_control_i
    (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
     .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
     .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
     .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_req, .host_wr, .host_addr,
     .host_bank, .host_ack, .mem_cmd, .mem_addr_lines, .mem_bank_sel, .mem_cke,
     .refresh_busy);
  sdram_rows_model sdram_rows_model_i
    (.aclk, .mem_cke, .mem_cmd, .mem_addr_lines, .mem_bank_sel, .n_cmd, .n_ref,
     .last_cmd, .last_addr, .act_gap);
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Handshakes are judged at the falling edge, where ready has settled
  task axw(input [11:0] a, input [7:0] v);
    reg ta, tw, tb;
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
        @(negedge aclk);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        tb = s_axi_bvalid;
        bs = s_axi_bresp;
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (tb) s_axi_bready <= 1'b0;
      end while (!tb);
    end
  endtask
  task axr(input [11:0] a, output [31:0] d, output [1:0] r);
    reg ta, tr;
    begin
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
        @(negedge aclk);
        ta = s_axi_arvalid && s_axi_arready;
        tr = s_axi_rvalid === 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        if (ta) s_axi_arvalid <= 1'b0;
        if (tr) s_axi_rready <= 1'b0;
      end while (!tr);
    end
  endtask
  task hcyc(input [11:0] a, input b, input w, output got);
    integer k;
    begin
      @(posedge aclk);
      host_addr <= a;
      host_bank <= b;
      host_wr   <= w;
      host_req  <= 1'b1;
      got = 1'b0;
      for (k = 0; k < 60 && !got; k = k + 1)
      begin
        @(negedge aclk);
        got = host_ack === 1'b1;
        @(posedge aclk);
      end
      host_req <= 1'b0;
    end
  endtask
  task give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`MT_ADDR, rd, rs);
    chk(rd, 32'h00000000);
    axr(12'h100, rd, rs);
    chk(rs, 2'h2);
    chk(rd, 32'h00000000);
    axw(`MT_ADDR, 8'hFF);
    chk(bs, 2'h0);
    axw(12'h100, 8'h5A);
    chk(bs, 2'h2);
    axr(`MT_ADDR, rd, rs);
    chk(rd[7:0], 8'hF7);
    axw(`MT_ADDR, 8'h00);
    t0 = n_cmd;
    hcyc(12'h03A, 1'b0, 1'b0, ok);
    chk(ok, 1'b0);
    chk(mem_cke, 1'b0);
    chk(n_cmd - t0, 32'h00000000);
    // Mode set address: burst 4, interleaved, CAS bit, 01, rest zero
    for (i = 4; i < 8; i = i + 1)
    begin
      axw(`MT_ADDR, {i[2:0], 5'h04});
      t0 = n_cmd;
      hcyc(12'h03A, 1'b0, 1'b0, ok);
      chk(ok, 1'b1);
      chk(n_cmd - t0, (i > 4) ? 32'h00000001 : 32'h00000000);
      if (i > 4) chk(last_cmd, i == 5 ? `CMD_PRE : i == 6 ? `CMD_MRS : `CMD_REF);
      if (i == 5) chk(last_addr[10], 1'b1);
      if (i == 6) chk(last_addr, 13'h003A);
    end
    // Long idle windows prove the refresh rate; the first period may be cut
    for (i = 1; i < 3; i = i + 1)
    begin
      axw(`MT_ADDR, {i[2:0], 5'h00});
      t0 = n_ref;
      repeat (10 * (i == 1 ? `REF156_CYC : `REF78_CYC)) @(posedge aclk);
      chk(n_ref - t0 >= 9 && n_ref - t0 <= 10, 1'b1);
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      axw(`MT_ADDR, {6'h08, i[0], 1'b0});
      hcyc(12'h123, 1'b1, i[0], ok);
      chk({ok, act_gap}, {1'b1, 4'h3 - i[3:0]});
    end
    give_verdict;
  end
  initial
  begin
    #(20000 * 100);
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
endmodule // test_sdram_mode_timing_control
